// ---- logic/dls_defines.svh ----
// Register map, field positions, reset values and encodings of the scroll engine
`ifndef DLS_DEFINES_SVH
`define DLS_DEFINES_SVH
// Register indices; byte address is four times the index
`define DLS_IDX_FETCH_CTRL 20'h0_d400
`define DLS_IDX_LIST_BASE 20'h0_d402
`define DLS_IDX_HFINE 20'h0_d404
`define DLS_IDX_VFINE 20'h0_d405
`define DLS_IDX_STATUS 20'h0_d40f
// Field positions inside a display list instruction
`define DLS_INS_LMS_BIT 6
`define DLS_INS_VSCR_BIT 5
`define DLS_INS_HSCR_BIT 4
`define DLS_INS_WAIT_BIT 6
// Instruction mode codes
`define DLS_MODE_BLANK 4'h0
`define DLS_MODE_JUMP 4'h1
// Playfield widths in color clocks
`define DLS_WIDTH_NARROW 8'h80
`define DLS_WIDTH_NORMAL 8'hA0
`define DLS_WIDTH_WIDE 8'hC0
// Reset values
`define DLS_RST_FETCH_CTRL 2'h2
`define DLS_RST_LIST_BASE 16'h0600
`endif

// ---- logic/dls_pkg.sv ----
// Types shared by the scroll engine
package dls_pkg;
    // Display list walker states
    typedef enum logic [2:0] {
        DLS_IDLE = 3'b000,
        DLS_OPCODE = 3'b001,
        DLS_OPER_LO = 3'b010,
        DLS_OPER_HI = 3'b011,
        DLS_DATA = 3'b100,
        DLS_BLANK = 3'b101,
        DLS_WAIT_VB = 3'b110
    } dls_state_type;
endpackage : dls_pkg

// ---- logic/dls_scroll_engine.sv ----
// Display list walker with coarse and fine scroll support and an APB register slave
//
// Function
// - Memory-scan-load flag reloads screen address from operand
// - Operand is first byte shown at left
// - Screen address counter wraps inside 4K block
// - Instruction bit D5 enables vertical fine scroll
// - Instruction bit D4 enables horizontal fine scroll
// - Horizontal fine offset register shifts color clocks
// - Vertical fine offset register shifts scan lines
// - Offsets apply only to enabled mode lines
// - Narrow, normal, wide widths 128/160/192
// - Horizontally scrolled lines fetch next wider width, staying wide at wide
// - Only low four offset bits are used
// - Steps are one line, one color clock
// - Byte 71 is large text with load
// - Byte 112 gives eight blank lines
// - Byte 65 jumps and waits for vertical blank
`include "dls_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dls_scroll_engine
    import dls_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [21:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Raster timing
    input wire logic i_vblank_start,
    // Memory read port
    output logic o_mem_req,
    output logic [15:0] o_mem_addr,
    input wire logic i_mem_ack,
    input wire logic [7:0] i_mem_data,
    // Screen byte stream
    output logic o_scr_valid,
    output logic [7:0] o_scr_data,
    // Mode line descriptor
    output logic o_line_valid,
    output logic [3:0] o_line_mode,
    output logic [3:0] o_line_hshift,
    output logic [3:0] o_line_vshift,
    output logic [5:0] o_line_bytes,
    output logic [15:0] o_line_addr,
    output logic [2:0] o_blank_lines
);
    // Reset synchroniser stages
    logic rst_meta;
    logic rst_n;
    // Software registers
    logic [1:0] fetch_ctrl;
    logic [15:0] list_base;
    logic [3:0] hfine;
    logic [3:0] vfine;
    // Walker state
    dls_state_type state;
    logic [15:0] list_ptr;
    logic [7:0] ins;
    logic [7:0] oper_lo;
    logic [15:0] scan_addr;
    logic [5:0] bytes_left;
    logic [5:0] line_bytes;
    // Decoded APB access
    logic apb_setup;
    logic apb_write;
    logic [19:0] apb_idx;
    logic apb_mapped;

    // Release reset through two flip-flops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Bytes fetched per line for a mode at a width in color clocks
    function automatic logic [5:0] line_len(input logic [3:0] mode, input logic [7:0] width);
        logic [7:0] len;
        len = 8'h00;
        if (mode < 4'h6) begin
            len = width >> 2;
        end else if (mode < 4'h8) begin
            len = width >> 3;
        end else if (mode < 4'hA) begin
            len = width >> 4;
        end else if (mode < 4'hD) begin
            len = width >> 3;
        end else begin
            len = width >> 2;
        end
        return len[5:0];
    endfunction : line_len

    // Width from fetch control, widened one step when horizontally scrolled below wide
    function automatic logic [7:0] pf_width(input logic [1:0] ctrl, input logic hscr);
        logic [7:0] w;
        w = 8'h00;
        if (ctrl == 2'h1) begin
            w = hscr ? `DLS_WIDTH_NORMAL : `DLS_WIDTH_NARROW;
        end else if (ctrl == 2'h2) begin
            // scrolled line fetches at wider rate
            w = hscr ? `DLS_WIDTH_WIDE : `DLS_WIDTH_NORMAL;
        end else if (ctrl == 2'h3) begin
            w = `DLS_WIDTH_WIDE;
        end
        return w;
    endfunction : pf_width

    // Address step that stays inside the current 4K block
    function automatic logic [15:0] wrap_inc(input logic [15:0] a);
        logic [11:0] low;
        low = a[11:0] + 12'h001;
        return {a[15:12], low};
    endfunction : wrap_inc

    // APB decode
    assign apb_setup = i_psel && !i_penable;
    // Writes to unmapped or misaligned addresses are dropped
    assign apb_write = i_psel && i_penable && i_pwrite && apb_mapped;
    assign apb_idx = i_paddr[21:2];
    assign apb_mapped = (i_paddr[1:0] == 2'b00) &&
        ((apb_idx == `DLS_IDX_FETCH_CTRL) || (apb_idx == `DLS_IDX_LIST_BASE) ||
         (apb_idx == `DLS_IDX_HFINE) || (apb_idx == `DLS_IDX_VFINE) ||
         (apb_idx == `DLS_IDX_STATUS));
    // Zero wait states; unmapped addresses answer with an error
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !apb_mapped;

    // Register writes, taken in the access cycle
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_ctrl <= `DLS_RST_FETCH_CTRL;
            list_base <= `DLS_RST_LIST_BASE;
            hfine <= 4'h0;
            vfine <= 4'h0;
        end else if (apb_write) begin
            if (apb_idx == `DLS_IDX_FETCH_CTRL) begin
                fetch_ctrl <= i_pwdata[1:0];
            end else if (apb_idx == `DLS_IDX_LIST_BASE) begin
                list_base <= i_pwdata[15:0];
            end else if (apb_idx == `DLS_IDX_HFINE) begin
                hfine <= i_pwdata[3:0];
            end else if (apb_idx == `DLS_IDX_VFINE) begin
                vfine <= i_pwdata[3:0];
            end
        end
    end

    // Read data captured in the setup cycle; offsets are write only
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_prdata <= 32'h0000_0000;
        end else if (apb_setup) begin
            if (apb_idx == `DLS_IDX_FETCH_CTRL) begin
                o_prdata <= {30'h0000_0000, fetch_ctrl};
            end else if (apb_idx == `DLS_IDX_LIST_BASE) begin
                o_prdata <= {16'h0000, list_base};
            end else if (apb_idx == `DLS_IDX_STATUS) begin
                o_prdata <= {scan_addr, 5'h00, state, ins};
            end else begin
                o_prdata <= 32'h0000_0000;
            end
        end
    end

    // Display list walker
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= DLS_IDLE;
            list_ptr <= 16'h0000;
            ins <= 8'h00;
            oper_lo <= 8'h00;
            scan_addr <= 16'h0000;
            bytes_left <= 6'h00;
            line_bytes <= 6'h00;
        end else begin
            case (state)
                // Start of frame restarts the list at its base from idle, or at the jump target after a wait
                DLS_IDLE, DLS_WAIT_VB: begin
                    if (i_vblank_start) begin
                        list_ptr <= (state == DLS_IDLE) ? list_base : list_ptr;
                        state <= DLS_OPCODE;
                    end
                end
                // Fetch and decode one instruction byte
                DLS_OPCODE: begin
                    if (i_mem_ack) begin
                        ins <= i_mem_data;
                        list_ptr <= list_ptr + 16'h0001;
                        line_bytes <= line_len(i_mem_data[3:0],
                            pf_width(fetch_ctrl, i_mem_data[`DLS_INS_HSCR_BIT]));
                        if (i_mem_data[3:0] == `DLS_MODE_BLANK) begin
                            state <= DLS_BLANK;
                        end else if (i_mem_data[3:0] == `DLS_MODE_JUMP ||
                                     i_mem_data[`DLS_INS_LMS_BIT]) begin
                            state <= DLS_OPER_LO;
                        end else begin
                            state <= DLS_DATA;
                        end
                        bytes_left <= line_len(i_mem_data[3:0],
                            pf_width(fetch_ctrl, i_mem_data[`DLS_INS_HSCR_BIT]));
                    end
                end
                // Operand low byte
                DLS_OPER_LO: begin
                    if (i_mem_ack) begin
                        oper_lo <= i_mem_data;
                        list_ptr <= list_ptr + 16'h0001;
                        state <= DLS_OPER_HI;
                    end
                end
                // Operand high byte
                DLS_OPER_HI: begin
                    if (i_mem_ack) begin
                        if (ins[3:0] == `DLS_MODE_JUMP) begin
                            // jump, waiting for vertical blank if asked
                            list_ptr <= {i_mem_data, oper_lo};
                            state <= ins[`DLS_INS_WAIT_BIT] ? DLS_WAIT_VB : DLS_OPCODE;
                        end else begin
                            // operand is the leftmost shown byte
                            scan_addr <= {i_mem_data, oper_lo};
                            list_ptr <= list_ptr + 16'h0001;
                            state <= DLS_DATA;
                        end
                    end
                end
                // Stream the line's screen bytes
                DLS_DATA: begin
                    if (bytes_left == 6'h00) begin
                        state <= DLS_OPCODE;
                    end else if (i_mem_ack) begin
                        // counter rolls over inside the 4K block
                        scan_addr <= wrap_inc(scan_addr);
                        bytes_left <= bytes_left - 6'h01;
                    end
                end
                // Blank lines take one cycle here
                DLS_BLANK: begin
                    state <= DLS_OPCODE;
                end
                default: begin
                    state <= DLS_IDLE;
                end
            endcase
        end
    end

    // Memory request and address
    assign o_mem_req = (state == DLS_OPCODE) || (state == DLS_OPER_LO) ||
        (state == DLS_OPER_HI) || ((state == DLS_DATA) && (bytes_left != 6'h00));
    assign o_mem_addr = (state == DLS_DATA) ? scan_addr : list_ptr;

    // Screen byte output
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_scr_valid <= 1'b0;
            o_scr_data <= 8'h00;
        end else begin
            o_scr_valid <= (state == DLS_DATA) && (bytes_left != 6'h00) && i_mem_ack;
            if ((state == DLS_DATA) && i_mem_ack) begin
                o_scr_data <= i_mem_data;
            end
        end
    end

    // Line descriptor, issued as a line enters data fetch or the blank state
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_line_valid <= 1'b0;
            o_line_mode <= 4'h0;
            o_line_hshift <= 4'h0;
            o_line_vshift <= 4'h0;
            o_line_bytes <= 6'h00;
            o_line_addr <= 16'h0000;
            o_blank_lines <= 3'h0;
        end else begin
            // One pulse per mode line, on the edge that loads its last field
            o_line_valid <= i_mem_ack &&
                ((state == DLS_OPCODE && i_mem_data[3:0] != `DLS_MODE_JUMP &&
                  !(i_mem_data[`DLS_INS_LMS_BIT] && i_mem_data[3:0] != `DLS_MODE_BLANK)) ||
                 (state == DLS_OPER_HI && ins[3:0] != `DLS_MODE_JUMP));
            if ((state == DLS_OPCODE || state == DLS_OPER_HI) && i_mem_ack) begin
                o_line_mode <= (state == DLS_OPCODE) ? i_mem_data[3:0] : ins[3:0];
                // offsets sampled once per mode line
                // unit steps of line and color clock
                o_line_vshift <= ((state == DLS_OPCODE) ? i_mem_data[`DLS_INS_VSCR_BIT]
                    : ins[`DLS_INS_VSCR_BIT]) ? vfine : 4'h0;
                o_line_hshift <= ((state == DLS_OPCODE) ? i_mem_data[`DLS_INS_HSCR_BIT]
                    : ins[`DLS_INS_HSCR_BIT]) ? hfine : 4'h0;
                o_line_bytes <= line_bytes;
                o_blank_lines <= (state == DLS_OPCODE) ? i_mem_data[6:4] : 3'h0;
            end
            if (state == DLS_OPER_HI && i_mem_ack) begin
                o_line_addr <= {i_mem_data, oper_lo};
            end else if (state == DLS_OPCODE && i_mem_ack) begin
                o_line_addr <= scan_addr;
            end
            if (state == DLS_OPCODE && i_mem_ack) begin
                o_line_bytes <= line_len(i_mem_data[3:0],
                    pf_width(fetch_ctrl, i_mem_data[`DLS_INS_HSCR_BIT]));
            end
        end
    end

    // Checks
    sequence s_ins_taken(logic [7:0] code);
        state == DLS_OPCODE && i_mem_ack && i_mem_data == code;
    endsequence

    // large text with load fetches two operand bytes
    a_lms_text_operand: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_ins_taken(8'h47) |=> state == DLS_OPER_LO)
        else $error("Large text with load did not fetch operand");
    // eight-line blank run fetches no screen data
    a_blank_run: assert property (@(posedge i_clk) disable iff (!rst_n)
        s_ins_taken(8'h70) |=> state == DLS_BLANK ##1 state == DLS_OPCODE)
        else $error("Blank run handled wrongly");
    // wait jump goes to wait state on high operand
    a_jump_wait: assert property (@(posedge i_clk) disable iff (!rst_n)
        state == DLS_OPER_HI && i_mem_ack && ins == 8'h41 |=>
        state == DLS_WAIT_VB && list_ptr == {$past(i_mem_data), oper_lo})
        else $error("Wait jump did not reload pointer");
    a_lms_load: assert property (@(posedge i_clk) disable iff (!rst_n)
        state == DLS_OPER_HI && i_mem_ack && ins[3:0] != `DLS_MODE_JUMP |=>
        state == DLS_DATA && o_mem_addr == {$past(i_mem_data), oper_lo})
        else $error("Screen address not loaded from operand");
    // counter stays in its 4K block
    a_wrap_4k: assert property (@(posedge i_clk) disable iff (!rst_n)
        state == DLS_DATA && i_mem_ack && bytes_left != 6'h00 |=>
        scan_addr[15:12] == $past(scan_addr[15:12]))
        else $error("Screen address left its 4K block");
    a_no_shift: assert property (@(posedge i_clk) disable iff (!rst_n)
        state == DLS_OPCODE && i_mem_ack && !i_mem_data[5] && !i_mem_data[4] |=>
        o_line_vshift == 4'h0 && o_line_hshift == 4'h0)
        else $error("Shift applied to unscrolled line");
    // normal width text line fetches 48 bytes when scrolled
    a_wide_fetch: assert property (@(posedge i_clk) disable iff (!rst_n)
        state == DLS_OPCODE && i_mem_ack && i_mem_data[3:0] == 4'h2 &&
        i_mem_data[4] && fetch_ctrl == 2'h2 |=> bytes_left == 6'd48)
        else $error("Scrolled line did not fetch wider");
    a_low_bits: assert property (@(posedge i_clk) disable iff (!rst_n)
        apb_write && apb_idx == `DLS_IDX_HFINE |=> hfine == $past(i_pwdata[3:0]))
        else $error("Horizontal offset not latched from low bits");
    // written offset reaches the next line
    a_offset_next: assert property (@(posedge i_clk) disable iff (!rst_n)
        apb_write && apb_idx == `DLS_IDX_VFINE ##1 state == DLS_OPCODE && i_mem_ack &&
        i_mem_data[5] && !apb_write |=> o_line_vshift == $past(vfine))
        else $error("Vertical offset not applied to next line");
endmodule : dls_scroll_engine
`default_nettype wire

// ---- dv/dls_host_mem.sv ----
// Memory partner that serves display list and screen bytes to the engine
`timescale 1ns/1ps
`default_nettype none
module dls_host_mem (
    // Clock
    input wire logic i_clk,
    // Fetch port from the engine
    input wire logic i_mem_req,
    input wire logic [15:0] i_mem_addr,
    output logic o_mem_ack,
    output logic [7:0] o_mem_data
);
    logic [7:0] ram [0:65535]; // Byte image of system memory
    logic [15:0] seen [$]; // Addresses served, in order
    int lat = 0; // Extra wait cycles before an answer
    int wait_cnt = 0; // Cycles the current request has waited

    // Quiet outputs at time zero
    initial begin
        o_mem_ack = 1'b0;
        o_mem_data = 8'h00;
    end

    // Answer after the chosen wait; idle data toggles so stale bytes never look valid
    always @(posedge i_clk) begin
        if (i_mem_req && !o_mem_ack && wait_cnt >= lat) begin
            o_mem_ack <= 1'b1;
            o_mem_data <= ram[i_mem_addr];
            seen.push_back(i_mem_addr);
            wait_cnt <= 0;
        end else begin
            o_mem_ack <= 1'b0;
            o_mem_data <= ~o_mem_data;
            wait_cnt <= (i_mem_req && !o_mem_ack) ? wait_cnt + 1 : 0;
        end
    end
endmodule : dls_host_mem
`default_nettype wire

// ---- dv/tb_display_list_scroll_engine.sv ----
// Self-checking bench for the display list scroll engine
`include "dls_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_display_list_scroll_engine;
    logic i_clk, i_nrst, i_psel, i_penable, i_pwrite, i_vblank_start; // Bench-driven controls
    logic [21:0] i_paddr; // APB address
    logic [31:0] i_pwdata, o_prdata; // APB data
    logic o_pready, o_pslverr, o_mem_req, i_mem_ack, o_scr_valid, o_line_valid; // Strobes
    logic [15:0] o_mem_addr, o_line_addr; // Addresses
    logic [7:0] i_mem_data, o_scr_data; // Bytes
    logic [3:0] o_line_mode, o_line_hshift, o_line_vshift; // Descriptor fields
    logic [5:0] o_line_bytes; // Bytes fetched for the line
    logic [2:0] o_blank_lines; // Blank run code
    int fail_count = 0; // Mismatches
    int compares = 0; // Comparisons made
    logic [15:0] exp_a [$]; // Expected fetch addresses
    logic [7:0] exp_d [$], scr_q [$]; // Expected and seen screen bytes
    logic [33:0] line_q [$]; // Seen mode line descriptors
    localparam logic [21:0] A_FC = {`DLS_IDX_FETCH_CTRL, 2'b00};
    localparam logic [21:0] A_LB = {`DLS_IDX_LIST_BASE, 2'b00};
    localparam logic [21:0] A_HF = {`DLS_IDX_HFINE, 2'b00};
    localparam logic [21:0] A_VF = {`DLS_IDX_VFINE, 2'b00};

    dls_scroll_engine dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_vblank_start(i_vblank_start), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
        .i_mem_ack(i_mem_ack), .i_mem_data(i_mem_data), .o_scr_valid(o_scr_valid),
        .o_scr_data(o_scr_data), .o_line_valid(o_line_valid), .o_line_mode(o_line_mode),
        .o_line_hshift(o_line_hshift), .o_line_vshift(o_line_vshift),
        .o_line_bytes(o_line_bytes), .o_line_addr(o_line_addr), .o_blank_lines(o_blank_lines));

    dls_host_mem mem (.i_clk(i_clk), .i_mem_req(o_mem_req), .i_mem_addr(o_mem_addr),
        .o_mem_ack(i_mem_ack), .o_mem_data(i_mem_data));

    // Free-running 100 ns clock
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    // Collect screen bytes and non-blank line descriptors
    always @(posedge i_clk) begin
        if (o_scr_valid === 1'b1) begin
            scr_q.push_back(o_scr_data);
        end
        if (o_line_valid === 1'b1 && o_line_mode !== 4'h0) begin
            line_q.push_back({o_line_mode, o_line_hshift, o_line_vshift, o_line_bytes, o_line_addr});
        end
    end

    // Verdict and end of run
    task automatic test_done();
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // Compare one value
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [21:0] addr, input logic [31:0] wdata,
                       input logic [31:0] exp, input logic exp_err);
        int n;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_pwrite <= wr;
        i_paddr <= addr;
        i_pwdata <= wdata;
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1) begin
            fail_count++;
            $display("wrong value at %0t: bus answer missing", $time);
            test_done();
        end
        check(o_pslverr, exp_err);
        if (!wr) begin
            check(o_prdata, exp);
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    // Expected fetches of one screen run
    task automatic add_run(input logic [15:0] base, input logic [5:0] cnt);
        logic [15:0] a;
        for (int n = 0; n < cnt; n++) begin
            a = {base[15:12], base[11:0] + 12'(n)};
            exp_a.push_back(a);
            exp_d.push_back(a[7:0] ^ a[15:8]);
        end
    endtask : add_run

    // One frame of the fixed display list under given width, offsets and memory wait
    task automatic run_frame(input logic [1:0] fc, input logic [7:0] hf, input logic [7:0] vf,
                             input int lat);
        logic [5:0] nu, ns;
        int n;
        nu = (fc == 2'h1) ? 6'h10 : (fc == 2'h2) ? 6'h14 : 6'h18;
        ns = (fc == 2'h1) ? 6'd40 : 6'd48;
        mem.lat = lat;
        apb(1'b1, A_FC, {30'h0, fc}, 32'h0, 1'b0);
        apb(1'b0, A_FC, 32'h0, {30'h0, fc}, 1'b0);
        apb(1'b1, A_HF, {24'h0, hf}, 32'h0, 1'b0);
        apb(1'b1, A_VF, {24'h0, vf}, 32'h0, 1'b0);
        exp_a = {16'h0600, 16'h0601, 16'h0602, 16'h0603};
        add_run(16'h0ffe, nu);
        exp_a.push_back(16'h0604);
        exp_a.push_back(16'h0605);
        exp_a.push_back(16'h0606);
        add_run(16'h2100, nu);
        exp_a.push_back(16'h0607);
        add_run(16'h2100 + 16'(nu), ns);
        exp_a.push_back(16'h0608);
        exp_a.push_back(16'h0609);
        exp_a.push_back(16'h060a);
        @(posedge i_clk);
        i_vblank_start <= 1'b1;
        @(posedge i_clk);
        i_vblank_start <= 1'b0;
        n = 0;
        while (mem.seen.size() < exp_a.size() && n < 3000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 3000) begin
            fail_count++;
            $display("wrong value at %0t: frame fetches missing", $time);
            test_done();
        end
        repeat (30) @(posedge i_clk);
        check(34'(mem.seen.size()), 34'(exp_a.size()));
        foreach (exp_a[i]) check(mem.seen[i], exp_a[i]);
        check(34'(scr_q.size()), 34'(exp_d.size()));
        foreach (exp_d[i]) check(scr_q[i], exp_d[i]);
        check(34'(line_q.size()), 34'h3);
        check(line_q[0], {4'h7, 4'h0, 4'h0, nu, 16'h0ffe});
        check(line_q[1], {4'h7, 4'h0, vf[3:0], nu, 16'h2100});
        check(line_q[2], {4'h2, hf[3:0], 4'h0, ns, 16'h2100 + 16'(nu)});
        mem.seen.delete();
        scr_q.delete();
        line_q.delete();
        exp_d.delete();
    endtask : run_frame

    // Main sequence
    initial begin
        {i_nrst, i_psel, i_penable, i_pwrite, i_vblank_start} = 5'h00;
        i_paddr = 22'h00_0000;
        i_pwdata = 32'h0000_0000;
        for (int a = 0; a < 65536; a++) mem.ram[a] = 8'(a) ^ 8'(a >> 8);
        // list: blanks, load line, vertical-only line, last line horizontally scrolled
        mem.ram[16'h0600] = 8'h70;
        {mem.ram[16'h0601], mem.ram[16'h0602], mem.ram[16'h0603]} = {8'h47, 8'hfe, 8'h0f};
        {mem.ram[16'h0604], mem.ram[16'h0605], mem.ram[16'h0606]} = {8'h67, 8'h00, 8'h21};
        mem.ram[16'h0607] = 8'h12;
        {mem.ram[16'h0608], mem.ram[16'h0609], mem.ram[16'h060a]} = {8'h41, 8'h00, 8'h06};
        repeat (4) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk);
        apb(1'b0, A_FC, 32'h0, 32'h0000_0002, 1'b0);
        apb(1'b0, A_LB, 32'h0, 32'h0000_0600, 1'b0);
        apb(1'b1, A_HF, 32'h0000_00f5, 32'h0, 1'b0);
        apb(1'b0, A_HF, 32'h0, 32'h0000_0000, 1'b0);
        apb(1'b0, A_VF, 32'h0, 32'h0000_0000, 1'b0);
        apb(1'b0, 22'h00_0004, 32'h0, 32'h0000_0000, 1'b1);
        apb(1'b1, A_HF | 22'h00_0001, 32'h0000_000e, 32'h0, 1'b1);
        run_frame(2'h2, 8'hf5, 8'h3a, 0);
        run_frame(2'h1, 8'h03, 8'h07, 3);
        run_frame(2'h3, 8'h1c, 8'hff, 1);
        test_done();
    end
endmodule : tb_display_list_scroll_engine
`default_nettype wire
